// *** common/phy_stats_params.svh ***
// offsets, field codes, reset values and timing counts of the phy statistics
`ifndef PHY_STATS_PARAMS_SVH
`define PHY_STATS_PARAMS_SVH

`define ADDR_LINK_INFO 8'h00
`define ADDR_ATT_PORTS 8'h04
`define ADDR_TX_ADDR_LO 8'h08
`define ADDR_TX_ADDR_HI 8'h0C
`define ADDR_ATT_ADDR_LO 8'h10
`define ADDR_ATT_ADDR_HI 8'h14
`define ADDR_EVT_DESC 8'h18
`define ADDR_EVT_CNT0 8'h20
`define ADDR_EVT_CNT1 8'h24
`define ADDR_EVT_CNT2 8'h28
`define ADDR_EVT_CNT3 8'h2C
`define ADDR_EVT_SRC 8'h30
`define ADDR_EVT_PEAK 8'h34
`define ADDR_RD_CMD_LO 8'h40
`define ADDR_RD_CMD_HI 8'h44
`define ADDR_WR_CMD_LO 8'h48
`define ADDR_WR_CMD_HI 8'h4C
`define ADDR_BLK_RX_LO 8'h50
`define ADDR_BLK_RX_HI 8'h54
`define ADDR_BLK_TX_LO 8'h58
`define ADDR_BLK_TX_HI 8'h5C
`define ADDR_UNSUP_FIRST 8'h60
`define ADDR_UNSUP_LAST 8'h7C
`define ADDR_IDLE_LO 8'h80
`define ADDR_IDLE_HI 8'h84
`define ADDR_TI_EXP 8'h88
`define ADDR_TI_INT 8'h8C
`define ADDR_STAT_PARAM 8'h90
`define ADDR_MODE 8'hA0

`define EVT_DESC_LEN 8'h0C
`define EVT_DESC_NUM 8'h04
`define EVT_SRC_INVALID 8'h01
`define EVT_SRC_DISPARITY 8'h02
`define EVT_SRC_SYNC_LOSS 8'h03
`define EVT_SRC_RESET_PROB 8'h04
`define EVT_PEAK_THRESH 32'h0000_0000
`define STAT_PARAM_CODE 16'h0001
`define STAT_PARAM_LEN 8'h40
`define RATE_BASE 2'b10
`define RATE_NONE 4'h0
`define REASON_CLEAR 4'h0
`define GEN_UNKNOWN 8'h00
`define GEN_WRAP 8'h01
`define GEN_MAX 8'hFF
`define MODE_RESET 8'h00

`define TI_EXPONENT 32'h0000_0002
`define TI_INTEGER 32'h0000_0005
`define IDLE_INTERVAL_MS 50
`define CLK_FREQ_MHZ 250
`define IDLE_TICK_CYCLES (`IDLE_INTERVAL_MS * 1000 * `CLK_FREQ_MHZ)

`endif

// *** common/phy_stats_pkg.sv ***
// types shared by the phy statistics block
package phy_stats_pkg;

    typedef struct packed {
        logic [2:0] dev_type;
        logic [3:0] reason;
        logic [2:0] init_ports;
        logic [2:0] tgt_ports;
        logic [63:0] sas_addr;
        logic [7:0] phy_id;
    } identify_rx_t;

    typedef struct packed {
        logic [3:0] reason;
        logic [63:0] sas_addr;
    } identify_tx_t;

    typedef struct packed {
        logic reset_problem;
        logic sync_loss;
        logic disparity;
        logic invalid_dword;
    } phy_events_t;

endpackage : phy_stats_pkg

// *** src/phy_stats.sv ***
// phy event counters, link information and general i/o statistics
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "phy_stats_params.svh"

module phy_stats
    import phy_stats_pkg::*;
#(
    parameter int BLK_W = 16,
    parameter int IDLE_TICK_CYCLES = `IDLE_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire phy_events_t phy_evt,
    input wire logic reset_seq_active,
    input wire logic dword_sync,
    input wire logic link_up,
    input wire logic phy_enabled,
    input wire logic [1:0] rate_sel,
    input wire logic virtual_phy,
    input wire logic sata_attached,
    input wire logic d2h_fis_rx,
    input wire logic id_rx_valid,
    input wire identify_rx_t id_rx,
    input wire logic id_tx_valid,
    input wire identify_tx_t id_tx,
    input wire logic rd_cmd,
    input wire logic wr_cmd,
    input wire logic blk_rx_valid,
    input wire logic [BLK_W-1:0] blk_rx_count,
    input wire logic blk_tx_valid,
    input wire logic [BLK_W-1:0] blk_tx_count,
    input wire logic task_set_empty,
    input wire logic cmd_active,
    output logic [7:0] generation
);

    localparam logic [31:0] EVT_MAX = 32'hFFFF_FFFF;
    localparam logic [31:0] TICK_LAST = 32'(IDLE_TICK_CYCLES - 1);

    logic [31:0] evt_cnt_reg [4];
    logic [3:0] evt_hit;
    logic [3:0] rate_reg;
    logic [3:0] reason_reg;
    logic [3:0] att_reason_reg;
    identify_rx_t att_reg;
    logic [63:0] tx_addr_reg;
    logic [7:0] gen_reg;
    logic [7:0] mode_reg;
    logic gen_bump;
    logic [63:0] rd_cmd_reg;
    logic [63:0] wr_cmd_reg;
    logic [63:0] blk_rx_reg;
    logic [63:0] blk_tx_reg;
    logic [63:0] idle_cnt_reg;
    logic [31:0] tick_reg;
    logic idle;
    logic idle_tick;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] snap_reg;
    logic [31:0] snap_next;
    logic snap_load;

    // event qualification
    assign evt_hit[0] = phy_evt.invalid_dword && !reset_seq_active;
    assign evt_hit[1] = phy_evt.disparity && dword_sync;
    assign evt_hit[2] = phy_evt.sync_loss;
    assign evt_hit[3] = phy_evt.reset_problem;

    // one saturating counter per event source
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_evt
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    evt_cnt_reg[g] <= 32'h0000_0000;
                end else if (evt_hit[g] && evt_cnt_reg[g] != EVT_MAX) begin
                    evt_cnt_reg[g] <= evt_cnt_reg[g] + 32'h0000_0001;
                end
            end
        end
    endgenerate

    // link rate from the last link reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_reg <= `RATE_NONE;
        end else if (link_up) begin
            if (phy_enabled) begin
                rate_reg <= {`RATE_BASE, rate_sel};
            end else begin
                rate_reg <= `RATE_NONE;
            end
        end
    end

    // received identify frame contents
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            att_reg <= '0;
        end else if (id_rx_valid) begin
            att_reg <= id_rx;
        end
    end

    // attached reason: virtual phy and sata fis force zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            att_reason_reg <= `REASON_CLEAR;
        end else if (virtual_phy) begin
            att_reason_reg <= `REASON_CLEAR;
        end else if (sata_attached && d2h_fis_rx) begin
            att_reason_reg <= `REASON_CLEAR;
        end else if (id_rx_valid) begin
            att_reason_reg <= id_rx.reason;
        end
    end

    // transmitted identify frame: own address and reset cause
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_addr_reg <= 64'h0000_0000_0000_0000;
            reason_reg <= `REASON_CLEAR;
        end else if (id_tx_valid) begin
            tx_addr_reg <= id_tx.sas_addr;
            reason_reg <= id_tx.reason;
        end
    end

    // mode settings; only a write that changes them bumps the generation
    assign gen_bump = wr && addr == `ADDR_MODE && wdata[7:0] != mode_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= `MODE_RESET;
        end else if (wr && addr == `ADDR_MODE) begin
            mode_reg <= wdata[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gen_reg <= `GEN_UNKNOWN;
        end else if (gen_bump) begin
            if (gen_reg == `GEN_MAX) begin
                gen_reg <= `GEN_WRAP;
            end else begin
                gen_reg <= gen_reg + 8'h01;
            end
        end
    end

    assign generation = gen_reg;

    // command and block statistics; 64 bits cannot wrap in service life
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_cmd_reg <= 64'h0000_0000_0000_0000;
            wr_cmd_reg <= 64'h0000_0000_0000_0000;
        end else begin
            if (rd_cmd) begin
                rd_cmd_reg <= rd_cmd_reg + 64'h0000_0000_0000_0001;
            end
            if (wr_cmd) begin
                wr_cmd_reg <= wr_cmd_reg + 64'h0000_0000_0000_0001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blk_rx_reg <= 64'h0000_0000_0000_0000;
            blk_tx_reg <= 64'h0000_0000_0000_0000;
        end else begin
            if (blk_rx_valid) begin
                blk_rx_reg <= blk_rx_reg + 64'(blk_rx_count);
            end
            if (blk_tx_valid) begin
                blk_tx_reg <= blk_tx_reg + 64'(blk_tx_count);
            end
        end
    end

    // idle divider holds its partial interval across busy periods
    assign idle = task_set_empty && !cmd_active;
    assign idle_tick = idle && tick_reg == TICK_LAST;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_reg <= 32'h0000_0000;
        end else if (idle_tick) begin
            tick_reg <= 32'h0000_0000;
        end else if (idle) begin
            tick_reg <= tick_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle_cnt_reg <= 64'h0000_0000_0000_0000;
        end else if (idle_tick) begin
            idle_cnt_reg <= idle_cnt_reg + 64'h0000_0000_0000_0001;
        end
    end

    // read mux; a counter low-word read snapshots the high word so that a
    // lo-then-hi pair is coherent even while the counter moves
    always_comb begin
        rdata_next = 32'h0000_0000;
        snap_next = 32'h0000_0000;
        snap_load = 1'b0;
        case (addr)
            `ADDR_LINK_INFO: begin
                rdata_next = {8'h00, gen_reg, 1'b0, att_reg.dev_type,
                              att_reason_reg, reason_reg, rate_reg};
            end
            `ADDR_ATT_PORTS: begin
                rdata_next = {16'h0000, att_reg.phy_id, 1'b0,
                              att_reg.tgt_ports, 1'b0, att_reg.init_ports};
            end
            `ADDR_TX_ADDR_LO: rdata_next = tx_addr_reg[31:0];
            `ADDR_TX_ADDR_HI: rdata_next = tx_addr_reg[63:32];
            `ADDR_ATT_ADDR_LO: rdata_next = att_reg.sas_addr[31:0];
            `ADDR_ATT_ADDR_HI: rdata_next = att_reg.sas_addr[63:32];
            `ADDR_EVT_DESC: begin
                rdata_next = {16'h0000, `EVT_DESC_NUM, `EVT_DESC_LEN};
            end
            `ADDR_EVT_CNT0: rdata_next = evt_cnt_reg[0];
            `ADDR_EVT_CNT1: rdata_next = evt_cnt_reg[1];
            `ADDR_EVT_CNT2: rdata_next = evt_cnt_reg[2];
            `ADDR_EVT_CNT3: rdata_next = evt_cnt_reg[3];
            `ADDR_EVT_SRC: begin
                rdata_next = {`EVT_SRC_RESET_PROB, `EVT_SRC_SYNC_LOSS,
                              `EVT_SRC_DISPARITY, `EVT_SRC_INVALID};
            end
            `ADDR_EVT_PEAK: rdata_next = `EVT_PEAK_THRESH;
            `ADDR_RD_CMD_LO: begin
                rdata_next = rd_cmd_reg[31:0];
                snap_next = rd_cmd_reg[63:32];
                snap_load = 1'b1;
            end
            `ADDR_WR_CMD_LO: begin
                rdata_next = wr_cmd_reg[31:0];
                snap_next = wr_cmd_reg[63:32];
                snap_load = 1'b1;
            end
            `ADDR_BLK_RX_LO: begin
                rdata_next = blk_rx_reg[31:0];
                snap_next = blk_rx_reg[63:32];
                snap_load = 1'b1;
            end
            `ADDR_BLK_TX_LO: begin
                rdata_next = blk_tx_reg[31:0];
                snap_next = blk_tx_reg[63:32];
                snap_load = 1'b1;
            end
            `ADDR_IDLE_LO: begin
                rdata_next = idle_cnt_reg[31:0];
                snap_next = idle_cnt_reg[63:32];
                snap_load = 1'b1;
            end
            `ADDR_RD_CMD_HI, `ADDR_WR_CMD_HI, `ADDR_BLK_RX_HI,
            `ADDR_BLK_TX_HI, `ADDR_IDLE_HI: begin
                rdata_next = snap_reg;
            end
            `ADDR_TI_EXP: rdata_next = `TI_EXPONENT;
            `ADDR_TI_INT: rdata_next = `TI_INTEGER;
            `ADDR_STAT_PARAM: begin
                rdata_next = {8'h00, `STAT_PARAM_LEN, `STAT_PARAM_CODE};
            end
            `ADDR_MODE: rdata_next = {24'h00_0000, mode_reg};
            default: begin
                // unsupported interval and weighted words fall here as zero
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            snap_reg <= 32'h0000_0000;
        end else if (rd && snap_load) begin
            snap_reg <= snap_next;
        end
    end

    assign rdata = rdata_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_rate_code: assert property (
        link_up && phy_enabled |=> rate_reg[3:2] == 2'b10
            && rate_reg[1:0] == $past(rate_sel))
        else $error("link rate code wrong after link reset");
    a_gen_nonzero: assert property (
        gen_bump && gen_reg != `GEN_MAX |=> gen_reg == $past(gen_reg) + 8'h01)
        else $error("generation did not step by one");
    a_gen_wrap: assert property (
        gen_bump && gen_reg == `GEN_MAX |=> gen_reg == `GEN_WRAP)
        else $error("generation did not wrap to 01h");
    a_invalid_gated: assert property (
        reset_seq_active |=> $stable(evt_cnt_reg[0]))
        else $error("invalid dword counted during phy reset");
    a_disp_nosync: assert property (
        !dword_sync |=> $stable(evt_cnt_reg[1]))
        else $error("disparity error counted without dword sync");
    a_sync_loss_step: assert property (
        phy_evt.sync_loss && evt_cnt_reg[2] != EVT_MAX
            |=> evt_cnt_reg[2] == $past(evt_cnt_reg[2]) + 32'h0000_0001)
        else $error("sync loss count did not step");
    a_reset_prob_sat: assert property (
        evt_cnt_reg[3] == EVT_MAX |=> evt_cnt_reg[3] == EVT_MAX)
        else $error("reset problem count left saturation");
    // a read right behind it legally refills rdata, so only a lone read
    // is checked for falling back to zero
    a_desc_read: assert property (
        rd && addr == `ADDR_EVT_DESC ##1 !rd
            |-> rdata == 32'h0000_040C ##1 rdata == 32'h0000_0000)
        else $error("event descriptor word wrong or held too long");
    a_virtual_reason: assert property (
        virtual_phy |=> att_reason_reg == `REASON_CLEAR)
        else $error("attached reason not cleared for virtual phy");
    a_wr_cmd_step: assert property (
        wr_cmd |=> wr_cmd_reg == $past(wr_cmd_reg) + 64'h0000_0000_0000_0001)
        else $error("write command count did not step");
    a_idle_hold: assert property (
        !idle |=> $stable(idle_cnt_reg) && $stable(tick_reg))
        else $error("idle time advanced while busy");

    c_gen_wrap: cover property (gen_bump && gen_reg == `GEN_MAX);
    c_idle_tick: cover property (idle_tick);
    c_hi_after_lo: cover property (rd && addr == `ADDR_RD_CMD_LO ##1
        rd && addr == `ADDR_RD_CMD_HI);
    c_sata_clear: cover property (sata_attached && d2h_fis_rx && !virtual_phy);

endmodule : phy_stats
`default_nettype wire

// *** verification/sas_link_peer.sv ***
// far-side phy model: line events, link reset and identify exchange
`timescale 1ns/1ps
`default_nettype none
module sas_link_peer
    import phy_stats_pkg::*;
(
    input wire logic clk,
    output var phy_events_t phy_evt,
    output logic reset_seq_active,
    output logic dword_sync,
    output logic link_up,
    output logic phy_enabled,
    output logic [1:0] rate_sel,
    output logic id_rx_valid,
    output var identify_rx_t id_rx,
    output logic id_tx_valid,
    output var identify_tx_t id_tx
);
    initial begin
        phy_evt = '0;
        reset_seq_active = 1'b0;
        dword_sync = 1'b1;
        link_up = 1'b0;
        phy_enabled = 1'b0;
        rate_sel = 2'h0;
        id_rx_valid = 1'b0;
        id_rx = '0;
        id_tx_valid = 1'b0;
        id_tx = '0;
    end
    // back-to-back event pulses, one per cycle
    task automatic events(input phy_events_t m, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            phy_evt <= m;
        end
        @(posedge clk);
        phy_evt <= '0;
    endtask : events
    task automatic gates(input logic rs, input logic ds);
        @(posedge clk);
        reset_seq_active <= rs;
        dword_sync <= ds;
    endtask : gates
    // rate lines are not held past the link reset pulse
    task automatic link_reset(input logic en, input logic [1:0] r);
        @(posedge clk);
        phy_enabled <= en;
        rate_sel <= r;
        link_up <= 1'b1;
        @(posedge clk);
        link_up <= 1'b0;
        rate_sel <= ~r;
    endtask : link_reset
    // frame fields are garbage once the valid pulse is over
    task automatic identify(input identify_rx_t r, input identify_tx_t t);
        @(posedge clk);
        id_rx <= r;
        id_tx <= t;
        id_rx_valid <= 1'b1;
        id_tx_valid <= 1'b1;
        @(posedge clk);
        id_rx_valid <= 1'b0;
        id_tx_valid <= 1'b0;
        id_rx <= ~r;
        id_tx <= ~t;
    endtask : identify
endmodule : sas_link_peer
`default_nettype wire

// *** verification/tb.sv ***
// testbench for the phy statistics block
`timescale 1ns/1ps
`default_nettype none
module tb
    import phy_stats_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [7:0] generation;
    phy_events_t phy_evt;
    identify_rx_t id_rx;
    identify_tx_t id_tx;
    logic reset_seq_active, dword_sync, link_up, phy_enabled;
    logic [1:0] rate_sel;
    logic id_rx_valid, id_tx_valid;
    logic virtual_phy = 1'b0;
    logic sata_attached = 1'b0;
    logic d2h_fis_rx = 1'b0;
    logic rd_cmd = 1'b0;
    logic wr_cmd = 1'b0;
    logic blk_rx_valid = 1'b0;
    logic blk_tx_valid = 1'b0;
    logic [15:0] blk_rx_count = 16'h0000;
    logic [15:0] blk_tx_count = 16'h0000;
    logic task_set_empty = 1'b0;
    logic cmd_active = 1'b0;
    int n_errors = 0;
    int cmp_count = 0;
    always #2 clk = ~clk;
    sas_link_peer p (.clk(clk), .phy_evt(phy_evt),
        .reset_seq_active(reset_seq_active), .dword_sync(dword_sync),
        .link_up(link_up), .phy_enabled(phy_enabled), .rate_sel(rate_sel),
        .id_rx_valid(id_rx_valid), .id_rx(id_rx),
        .id_tx_valid(id_tx_valid), .id_tx(id_tx));
    // short idle divider keeps the run brief
    phy_stats #(.BLK_W(16), .IDLE_TICK_CYCLES(10)) uut (.clk(clk),
        .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .phy_evt(phy_evt),
        .reset_seq_active(reset_seq_active), .dword_sync(dword_sync),
        .link_up(link_up), .phy_enabled(phy_enabled), .rate_sel(rate_sel),
        .virtual_phy(virtual_phy), .sata_attached(sata_attached),
        .d2h_fis_rx(d2h_fis_rx), .id_rx_valid(id_rx_valid), .id_rx(id_rx),
        .id_tx_valid(id_tx_valid), .id_tx(id_tx), .rd_cmd(rd_cmd),
        .wr_cmd(wr_cmd), .blk_rx_valid(blk_rx_valid),
        .blk_rx_count(blk_rx_count), .blk_tx_valid(blk_tx_valid),
        .blk_tx_count(blk_tx_count), .task_set_empty(task_set_empty),
        .cmd_active(cmd_active), .generation(generation));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got,
                exp);
        end
    endtask : chk
    // data taken mid-cycle; the task returns on a rising edge
    task automatic rd32(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask : rd32
    // low then high word back to back; a counter low read snapshots the high word
    task automatic rd64(input logic [7:0] a, output logic [63:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        addr <= a + 8'h04;
        @(negedge clk);
        d[31:0] = rdata;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d[63:32] = rdata;
        @(posedge clk);
    endtask : rd64
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr32
    task automatic t_const();
        logic [31:0] d;
        chk(generation, 8'h00);
        rd32(8'h18, d);
        chk(d, 32'h0000_040C);
        @(negedge clk);
        chk(rdata, 32'h0000_0000);
        wr32(8'h18, 32'h0000_FFFF);
        rd32(8'h18, d);
        chk(d, 32'h0000_040C);
        rd32(8'h30, d);
        chk(d, 32'h0403_0201);
        rd32(8'h34, d);
        chk(d, 32'h0000_0000);
        rd32(8'h88, d);
        chk(d, 32'h0000_0002);
        rd32(8'h8C, d);
        chk(d, 32'h0000_0005);
        rd32(8'h90, d);
        chk(d, 32'h0040_0001);
        rd32(8'hF0, d);
        chk(d, 32'h0000_0000);
        for (int a = 8'h60; a <= 8'h7C; a += 4) begin
            rd32(a[7:0], d);
            chk(d, 32'h0000_0000);
        end
        for (int a = 8'h20; a <= 8'h2C; a += 4) begin
            rd32(a[7:0], d);
            chk(d, 32'h0000_0000);
        end
        $display("test constants done");
    endtask : t_const
    task automatic t_events();
        logic [31:0] d;
        logic [31:0] exp[4] = '{32'h3, 32'h3, 32'h2, 32'h2};
        p.gates(1'b1, 1'b0);
        p.events(4'hF, 2);
        p.gates(1'b0, 1'b1);
        p.events(4'h3, 3);
        for (int i = 0; i < 4; i++) begin
            rd32(8'h20 + 8'(4 * i), d);
            chk(d, exp[i]);
        end
        $display("test events done");
    endtask : t_events
    task automatic t_link();
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            p.link_reset(1'b1, 2'(i));
            rd32(8'h00, d);
            chk(d[3:0], 4'h8 + 4'(i));
        end
        p.link_reset(1'b0, 2'h2);
        rd32(8'h00, d);
        chk(d[3:0], 4'h0);
        $display("test link rate done");
    endtask : t_link
    task automatic t_ident();
        logic [31:0] d;
        logic [63:0] q;
        identify_rx_t r;
        identify_tx_t t;
        r = '{3'h1, 4'h5, 3'h6, 3'h1, 64'h5000_1234_89AB_CDEF, 8'h07};
        t = '{4'h3, 64'h5000_CC00_0000_0011};
        p.identify(r, t);
        rd32(8'h00, d);
        chk(d[14:4], 11'h153);
        rd32(8'h04, d);
        chk(d, 32'h0000_0716);
        rd64(8'h10, q);
        chk(q, r.sas_addr);
        rd64(8'h08, q);
        chk(q, t.sas_addr);
        @(posedge clk);
        virtual_phy <= 1'b1;
        rd32(8'h00, d);
        chk(d[11:8], 4'h0);
        virtual_phy <= 1'b0;
        p.identify(r, t);
        rd32(8'h00, d);
        chk(d[11:8], 4'h5);
        sata_attached <= 1'b1;
        d2h_fis_rx <= 1'b1;
        @(posedge clk);
        d2h_fis_rx <= 1'b0;
        rd32(8'h00, d);
        chk(d[11:8], 4'h0);
        sata_attached <= 1'b0;
        $display("test identify done");
    endtask : t_ident
    task automatic t_gen();
        wr32(8'hA0, 32'h0000_0000);
        @(posedge clk);
        chk(generation, 8'h00);
        for (int i = 1; i < 256; i++) begin
            wr32(8'hA0, 32'(i));
        end
        @(posedge clk);
        chk(generation, 8'hFF);
        wr32(8'hA0, 32'h0000_0000);
        @(posedge clk);
        chk(generation, 8'h01);
        $display("test generation done");
    endtask : t_gen
    task automatic t_io();
        logic [63:0] q;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            rd_cmd <= 1'b1;
            wr_cmd <= (i < 2);
            blk_rx_valid <= 1'b1;
            blk_rx_count <= (i == 0) ? 16'h0100 : 16'h0023;
            blk_tx_valid <= (i < 2);
            blk_tx_count <= 16'hFFFF;
        end
        @(posedge clk);
        {rd_cmd, wr_cmd, blk_rx_valid, blk_tx_valid} <= 4'h0;
        rd64(8'h40, q);
        chk(q, 64'h3);
        rd64(8'h48, q);
        chk(q, 64'h2);
        rd64(8'h50, q);
        chk(q, 64'h146);
        rd64(8'h58, q);
        chk(q, 64'h1_FFFE);
        $display("test io stats done");
    endtask : t_io
    // idle spans chosen off tick boundaries so one cycle of skew is harmless
    task automatic t_idle();
        logic [63:0] q;
        rd64(8'h80, q);
        chk(q, 64'h0);
        @(posedge clk);
        task_set_empty <= 1'b1;
        repeat (25) @(posedge clk);
        task_set_empty <= 1'b0;
        rd64(8'h80, q);
        chk(q, 64'h2);
        task_set_empty <= 1'b1;
        cmd_active <= 1'b1;
        repeat (40) @(posedge clk);
        cmd_active <= 1'b0;
        repeat (10) @(posedge clk);
        task_set_empty <= 1'b0;
        rd64(8'h80, q);
        chk(q, 64'h3);
        $display("test idle done");
    endtask : t_idle
    task automatic test_done();
        $display("compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    initial begin
        #100000;
        n_errors++;
        $display("wrong value at %0t: run hung", $time);
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_const();
        t_events();
        t_link();
        t_ident();
        t_gen();
        t_io();
        t_idle();
        test_done();
    end
endmodule : tb
`default_nettype wire
